// ---- pnprc_page_capture.sv ----
// Holding register for the next page received from the link partner
`timescale 1ns/1ps
module pnprc_page_capture
    import pnprc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_page_valid,
    input wire pnprc_page_t i_page,
    output pnprc_page_t o_page
);
    pnprc_page_t page;
    pnprc_page_t next_page;

    always_comb
    begin
        next_page = page;
        if (i_page_valid)
        begin
            next_page = i_page; // R14
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            page <= pnprc_page_t'(PNPRC_PAGE_RESET); // R6
        end
        else
        begin
            page <= next_page;
        end
    end

    assign o_page = page;
endmodule

// ---- pnprc_partner.sv ----
// Link partner model handing accepted next pages to the block
`timescale 1ns/1ps
module pnprc_partner
(
    input wire logic i_clk,
    input wire logic i_send,
    input wire logic [15:0] i_word,
    output logic o_valid = 1'b0,
    output logic [15:0] o_page = 16'h0000
);
    always @(posedge i_clk)
    begin
        o_valid <= #1 i_send;
        o_page <= #1 i_send ? i_word : ~o_page;
    end
endmodule

// ---- pnprc_pkg.sv ----
// Constants and carrier types for the next-page receive and port configuration registers
package pnprc_pkg;
    localparam logic [4:0] PNPRC_ADDR_PARTNER_NEXT_PAGE_RECEIVE = 5'h08;
    localparam logic [4:0] PNPRC_ADDR_PORT_CONFIGURATION = 5'h10;
    localparam logic [15:0] PNPRC_PAGE_RESET = 16'h0000;
    localparam int PNPRC_CFG_RESERVED_HI_BIT = 15;
    localparam int PNPRC_CFG_FORCE_LINK_PASS_BIT = 14;
    localparam int PNPRC_CFG_TX_DISABLE_BIT = 13;
    localparam int PNPRC_CFG_SCRAMBLER_BYPASS_BIT = 12;
    localparam int PNPRC_CFG_RESERVED_LO_BIT = 11;
    localparam int PNPRC_CFG_JABBER_DISABLE_BIT = 10;
    localparam int PNPRC_CFG_STRAP_BIT = 0;
    // Reset of bits 15..1; bit 0 comes from the strap pin
    localparam logic [15:0] PNPRC_CFG_RESET = 16'h0000;
    // Writable bits: reserved 15 and 11 are kept at zero
    localparam logic [15:0] PNPRC_CFG_WRITE_MASK = 16'h77FF;
    localparam logic [15:0] PNPRC_UNMAPPED_READ = 16'h0000;

    typedef struct packed {
        logic more_pages_flag;
        logic ack;
        logic message_page_flag;
        logic comply_flag;
        logic toggle;
        logic [10:0] code_field;
    } pnprc_page_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [15:0] wdata;
    } pnprc_mgmt_req_t;
endpackage

// ---- pnprc_regs.sv ----
// Per-port next-page receive register and port configuration register
// How it works
// R1: Bit 15 of the received next-page register says whether the partner has more pages.
// R2: Bit 14 says whether the partner acknowledged our link code word.
// R3: Bit 13 says whether the partner's page is a message page or unformatted.
// R4: Bit 12 says whether the partner will comply with the message.
// R5: Bit 11 holds the partner's toggle bit as received.
// R6: Bits 10 to 0 hold the partner's 11-bit code field, read-only, reset to zero.
// R7: Force link pass drives link status and link indicator to pass.
// R8: Transmit disable turns the twisted-pair transmitter off.
// R9: Scrambler bypass skips scrambler and descrambler in 100 Mb/s twisted-pair mode.
// R10: Jabber disable turns jabber protection off in 10 Mb/s operation.
// R11: Software writes zero to reserved bits 15 and 11 and ignores them on read.
// R12: Bit 0 of the configuration register resets to the strap pin level.
// R13: Bits 14, 13, 12 and 10 are read/write and reset to zero.
// R14: Each next page accepted from the partner updates the received register.
`timescale 1ns/1ps
module pnprc_regs
    import pnprc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire pnprc_mgmt_req_t i_mgmt_req,
    input wire logic i_page_valid,
    input wire pnprc_page_t i_page,
    input wire logic i_fiber_or_twisted_pair_strap,
    input wire logic i_speed_100,
    input wire logic i_link_ok,
    output logic [15:0] o_mgmt_rdata,
    output logic o_mgmt_rvalid,
    output logic o_link_status,
    output logic o_link_led,
    output logic o_tx_enable,
    output logic o_scrambler_bypass,
    output logic o_jabber_protect_en,
    output logic [15:0] o_port_config
);
    pnprc_page_t rx_page;
    logic [15:0] cfg;
    logic [15:0] next_cfg;
    logic [15:0] rdata;
    logic [15:0] next_rdata;
    logic rvalid;
    logic next_rvalid;
    logic link_status;
    logic next_link_status;
    logic link_led;
    logic next_link_led;
    logic tx_enable;
    logic next_tx_enable;
    logic scr_bypass;
    logic next_scr_bypass;
    logic jabber_en;
    logic next_jabber_en;
    logic twisted_pair;
    logic cfg_wr;
    logic cfg_rd;
    logic page_rd;

    // Captured next page lives in a small holding module of its own
    pnprc_page_capture u_page_capture (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_page_valid(i_page_valid),
        .i_page(i_page),
        .o_page(rx_page)
    );

    // A write to the page register or to an unmapped address
    // matches nothing here and is dropped
    assign cfg_wr = i_mgmt_req.wr && (i_mgmt_req.addr == PNPRC_ADDR_PORT_CONFIGURATION);
    assign cfg_rd = i_mgmt_req.rd && (i_mgmt_req.addr == PNPRC_ADDR_PORT_CONFIGURATION);
    assign page_rd = i_mgmt_req.rd
        && (i_mgmt_req.addr == PNPRC_ADDR_PARTNER_NEXT_PAGE_RECEIVE);

    // Strap low selects twisted pair for this port
    assign twisted_pair = ~cfg[PNPRC_CFG_STRAP_BIT];

    // Cells outside the write mask only ever load zero, so reserved
    // bits read back zero even when software breaks the write rule
    for (genvar b = 0; b < 16; b++)
    begin : g_cfg_bit
        always_comb
        begin
            next_cfg[b] = cfg[b];
            if (cfg_wr)
            begin
                next_cfg[b] = i_mgmt_req.wdata[b] & PNPRC_CFG_WRITE_MASK[b]; // R13 R11
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            // Synchronous reset lets the strap be sampled here
            cfg <= PNPRC_CFG_RESET; // R13
            cfg[PNPRC_CFG_STRAP_BIT] <= i_fiber_or_twisted_pair_strap; // R12
        end
        else
        begin
            cfg <= next_cfg;
        end
    end

    // Valid is a single-cycle strobe, raised for every read, mapped or not
    always_comb
    begin
        next_rvalid = i_mgmt_req.rd;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            rvalid <= 1'b0;
        end
        else
        begin
            rvalid <= next_rvalid;
        end
    end

    // Read data holds between reads; a read in the same cycle as a
    // write or a new page returns the value from before that edge
    always_comb
    begin
        next_rdata = rdata;
        if (page_rd)
        begin
            next_rdata = rx_page; // R1 R2 R3 R4 R5 R6
        end
        else if (cfg_rd)
        begin
            next_rdata = cfg;
        end
        else if (i_mgmt_req.rd)
        begin
            next_rdata = PNPRC_UNMAPPED_READ;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            rdata <= 16'h0000;
        end
        else
        begin
            rdata <= next_rdata;
        end
    end

    // Forcing only ever raises the link; it cannot hide a real pass
    always_comb
    begin
        next_link_status = i_link_ok | cfg[PNPRC_CFG_FORCE_LINK_PASS_BIT]; // R7
        next_link_led = i_link_ok | cfg[PNPRC_CFG_FORCE_LINK_PASS_BIT]; // R7
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            link_status <= 1'b0;
            link_led <= 1'b0;
        end
        else
        begin
            link_status <= next_link_status;
            link_led <= next_link_led;
        end
    end

    // Transmitter stays off while reset is held
    always_comb
    begin
        next_tx_enable = ~cfg[PNPRC_CFG_TX_DISABLE_BIT]; // R8
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            tx_enable <= 1'b0;
        end
        else
        begin
            tx_enable <= next_tx_enable;
        end
    end

    // Coding controls lag the configuration register by one cycle
    always_comb
    begin
        next_scr_bypass = cfg[PNPRC_CFG_SCRAMBLER_BYPASS_BIT] & i_speed_100
            & twisted_pair; // R9
        // Jabber only exists at 10 Mb/s, so the bit has no effect at 100
        next_jabber_en = ~i_speed_100 & ~cfg[PNPRC_CFG_JABBER_DISABLE_BIT]; // R10
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            scr_bypass <= 1'b0;
            jabber_en <= 1'b0;
        end
        else
        begin
            scr_bypass <= next_scr_bypass;
            jabber_en <= next_jabber_en;
        end
    end

    assign o_mgmt_rdata = rdata;
    assign o_mgmt_rvalid = rvalid;
    assign o_link_status = link_status;
    assign o_link_led = link_led;
    assign o_tx_enable = tx_enable;
    assign o_scrambler_bypass = scr_bypass;
    assign o_jabber_protect_en = jabber_en;
    assign o_port_config = cfg;
endmodule

// ---- pnprc_regs_sva.sv ----
// Port assertions for the register bank
`timescale 1ns/1ps
module pnprc_regs_sva
    import pnprc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire pnprc_mgmt_req_t i_mgmt_req,
    input wire logic o_mgmt_rvalid,
    input wire logic o_link_status,
    input wire logic o_link_led,
    input wire logic o_tx_enable,
    input wire logic o_scrambler_bypass,
    input wire logic o_jabber_protect_en,
    input wire logic [15:0] o_port_config
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    sequence cfg_wr_s;
        i_mgmt_req.wr && i_mgmt_req.addr == 5'h10;
    endsequence
    rd_answer_a: assert property (
        1 |=> o_mgmt_rvalid == $past(i_mgmt_req.rd)) else $error("read valid");
    cfg_write_a: assert property (
        cfg_wr_s |=> o_port_config == ($past(i_mgmt_req.wdata) & 16'h77FF)) else $error("write");
    rsvd_zero_a: assert property (
        !o_port_config[15] && !o_port_config[11]) else $error("reserved");
    link_pass_a: assert property (
        o_port_config[14] |=> o_link_status) else $error("link");
    led_follow_a: assert property (
        o_link_led == o_link_status) else $error("led");
    tx_off_a: assert property (
        1 |=> o_tx_enable == !$past(o_port_config[13])) else $error("tx");
    scram_off_a: assert property (
        !o_port_config[12] |=> !o_scrambler_bypass) else $error("scrambler");
    jabber_off_a: assert property (
        o_port_config[10] |=> !o_jabber_protect_en) else $error("jabber");
endmodule
bind pnprc_regs pnprc_regs_sva i_sva (.*);

// ---- pnprc_regs_tb_top.sv ----
// Self-checking bench for the register bank
`timescale 1ns/1ps
module pnprc_regs_tb_top
    import pnprc_pkg::*;
;
    logic i_clk = 0, i_reset = 1, i_fiber_or_twisted_pair_strap = 1, i_speed_100 = 0;
    logic i_link_ok = 0, s = 0, i_page_valid, o_mgmt_rvalid, o_link_status, o_link_led;
    logic o_tx_enable, o_scrambler_bypass, o_jabber_protect_en;
    logic [15:0] w = 16'h0000, d, c, i_page, o_mgmt_rdata, o_port_config;
    pnprc_mgmt_req_t i_mgmt_req = '0;
    int n_mismatch = 0, comparisons = 0;
    pnprc_partner i_lp (.i_clk, .i_send(s), .i_word(w), .o_valid(i_page_valid), .o_page(i_page));
    pnprc_regs i_dut (.*);
    always #25 i_clk = ~i_clk;
    task tick;
        @(posedge i_clk) #1;
    endtask
    task cmp(input logic [15:0] g, e);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %0t %h %h", $time, g, e);
        end
    endtask
    // Read expectation rides in wdata, which a read ignores
    task xfer(input logic wr, rd, input logic [4:0] a, input logic [15:0] x);
        i_mgmt_req = '{wr, rd, a, x};
        tick;
        cmp(16'(o_mgmt_rvalid), 16'(rd));
        if (rd)
            cmp(o_mgmt_rdata, x);
        i_mgmt_req = '0;
        tick;
        cmp(16'(o_mgmt_rvalid), 16'h0000);
    endtask
    task end_sim;
        $display("checks %0d errors %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        #20000 n_mismatch++;
        end_sim;
    end
    initial
    begin
        void'($urandom(39));
        repeat (3) tick;
        i_reset = 0;
        xfer(0, 1, 5'h10, 16'h0001);
        xfer(0, 1, 5'h08, 16'h0000);
        repeat (8)
        begin
            {d, w, i_speed_100, i_link_ok} = 34'({$urandom, $urandom});
            s = 1;
            tick;
            s = 0;
            xfer(1, 0, 5'h10, d);
            c = d & PNPRC_CFG_WRITE_MASK;
            xfer(0, 1, 5'h10, c);
            cmp(o_port_config, c);
            cmp(16'({o_link_status, o_link_led, o_tx_enable, o_scrambler_bypass,
                o_jabber_protect_en}), 16'({c[14] | i_link_ok, c[14] | i_link_ok, !c[13],
                c[12] & i_speed_100 & !c[0], !(i_speed_100 | c[10])}));
            xfer(1, 0, 5'h08, d);
            xfer(0, 1, 5'h08, w);
        end
        xfer(0, 1, 5'h1F, PNPRC_UNMAPPED_READ);
        i_reset = 1;
        i_fiber_or_twisted_pair_strap = 0;
        repeat (3) tick;
        i_reset = 0;
        xfer(0, 1, 5'h10, 16'h0000);
        xfer(0, 1, 5'h08, 16'h0000);
        end_sim;
    end
endmodule
